/* rtl/phy_autoneg_vendor_regs.v */
`include "phy_cfg_consts.vh"

module phy_autoneg_vendor_regs #(
  parameter SM_RESET_CYCLES = `SM_RESET_CYCLES
) (
  // Clock and reset
  input  wire                     clk_i,
  input  wire                     rstn_i,
  // Management register port
  input  wire [`REG_ADDR_W-1:0]   reg_addr_i,
  input  wire                     reg_wr_i,
  input  wire [`REG_DATA_W-1:0]   reg_wdata_i,
  input  wire                     reg_rd_i,
  output wire [`REG_DATA_W-1:0]   reg_rdata_o,
  output wire                     reg_rvalid_o,
  // Auto-negotiation engine status
  input  wire                     parallel_detect_fault_i,
  input  wire                     page_received_i,
  input  wire                     partner_next_page_i,
  input  wire                     partner_autoneg_i,
  // Strap pins
  input  wire                     repeater_strap_i,
  input  wire                     rmii_strap_i,
  // Line and LED status from the PHY core
  input  wire                     line_link_100_i,
  input  wire                     speed_100_i,
  input  wire                     full_duplex_i,
  input  wire                     collision_i,
  // Coding path controls
  output wire                     bypass_block_coding_o,
  output wire                     bypass_scrambling_o,
  output wire                     bypass_symbol_alignment_o,
  output wire                     bypass_adaptation_ok_o,
  // Mode controls
  output wire                     repeater_mode_o,
  output wire                     tx100_mode_o,
  output wire                     rmii_enable_o,
  output wire                     auto_power_down_enable_o,
  output wire                     mgmt_preamble_suppress_o,
  output wire                     sleep_o,
  output wire                     remote_loopback_o,
  output wire                     state_machine_reset_o,
  // Link and LED outputs
  output wire                     link_100_good_o,
  output wire                     speed_led_o,
  output wire                     fdx_col_led_o
);

  // Register state
  reg  [`REG_DATA_W-1:0] cfg_reg;
  reg  [`REG_DATA_W-1:0] cfg_next;
  reg                    pdf_reg;
  reg                    pdf_next;
  reg                    page_rx_reg;
  reg                    page_rx_next;
  reg                    partner_np_reg;
  reg                    partner_an_reg;
  reg  [`SM_CNT_W-1:0]   sm_cnt_reg;
  reg  [`SM_CNT_W-1:0]   sm_cnt_next;
  reg  [1:0]             strap_cnt_reg;
  reg  [`REG_DATA_W-1:0] rdata_reg;
  reg  [`REG_DATA_W-1:0] rdata_next;
  reg                    rvalid_reg;
  reg                    link_good_reg;
  reg                    speed_led_reg;
  reg                    fdx_led_reg;
  reg                    byp_coding_reg;
  reg                    byp_scr_reg;
  reg                    sm_rst_reg;

  // Decode
  wire                   sel_exp;
  wire                   sel_vcfg;
  wire                   wr_vcfg;
  wire                   rd_exp;
  wire                   strap_load;
  wire                   wake;
  wire                   sm_start;
  wire                   sm_active;
  wire [1:0]             strap_sync;
  wire [`REG_DATA_W-1:0] exp_value;
  wire [`REG_DATA_W-1:0] vcfg_value;

  assign sel_exp  = (reg_addr_i == `ADDR_AUTONEG_EXPANSION);
  assign sel_vcfg = (reg_addr_i == `ADDR_VENDOR_CONFIG);
  assign wr_vcfg  = reg_wr_i & sel_vcfg;
  assign rd_exp   = reg_rd_i & sel_exp;

  // Strap pins come from outside the clock domain
  pin_sync #(
    .WIDTH (2)
  ) u_strap_sync (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .pin_i  ({repeater_strap_i, rmii_strap_i}),
    .sync_o (strap_sync)
  );

  // Straps are captured once the synchroniser has filled after reset release
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      strap_cnt_reg <= 2'h0;
    end
    else if (strap_cnt_reg != `STRAP_DONE_COUNT)
    begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end

  assign strap_load = (strap_cnt_reg == `STRAP_LOAD_COUNT);

  // Wake from sleep restarts the state machines but keeps the settings
  assign wake     = wr_vcfg & cfg_reg[`VCFG_SLEEP_BIT] & ~reg_wdata_i[`VCFG_SLEEP_BIT];
  assign sm_start = (wr_vcfg & reg_wdata_i[`VCFG_SM_RESET_BIT]) | wake;
  assign sm_active = (sm_cnt_reg != {`SM_CNT_W{1'b0}});

  // Vendor configuration register
  always @*
  begin
    cfg_next = cfg_reg;
    if (wr_vcfg)
    begin
      cfg_next = (reg_wdata_i & `VCFG_RW_MASK) | (cfg_reg & ~`VCFG_RW_MASK);
    end
    if (strap_load)
    begin
      cfg_next[`VCFG_REPEATER_BIT] = strap_sync[1];
      cfg_next[`VCFG_RMII_BIT]     = strap_sync[0];
    end
    cfg_next[`VCFG_RESERVED_BIT] = `VCFG_RESERVED_VALUE;
    cfg_next[`VCFG_SM_RESET_BIT] = 1'b0;
  end

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      cfg_reg <= `VCFG_RESET_VALUE;
    end
    else
    begin
      cfg_reg <= cfg_next;
    end
  end

  // State machine reset pulse; a new request restarts the count
  always @*
  begin
    sm_cnt_next = sm_cnt_reg;
    if (sm_start)
    begin
      sm_cnt_next = SM_RESET_CYCLES[`SM_CNT_W-1:0];
    end
    else if (sm_active)
    begin
      sm_cnt_next = sm_cnt_reg - {{(`SM_CNT_W-1){1'b0}}, 1'b1};
    end
  end

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sm_cnt_reg <= {`SM_CNT_W{1'b0}};
    end
    else
    begin
      sm_cnt_reg <= sm_cnt_next;
    end
  end

  // Latched status; a new event in the read cycle survives the clear
  always @*
  begin
    pdf_next     = pdf_reg;
    page_rx_next = page_rx_reg;
    if (rd_exp)
    begin
      pdf_next     = 1'b0;
      page_rx_next = 1'b0;
    end
    if (parallel_detect_fault_i)
    begin
      pdf_next = 1'b1;
    end
    if (page_received_i)
    begin
      page_rx_next = 1'b1;
    end
  end

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      pdf_reg        <= 1'b0;
      page_rx_reg    <= 1'b0;
      partner_np_reg <= 1'b0;
      partner_an_reg <= 1'b0;
    end
    else
    begin
      pdf_reg        <= pdf_next;
      page_rx_reg    <= page_rx_next;
      partner_np_reg <= partner_next_page_i;
      partner_an_reg <= partner_autoneg_i;
    end
  end

  // Read images
  assign exp_value = {`EXP_RESERVED_VALUE,
                      pdf_reg,
                      partner_np_reg,
                      1'b0,
                      page_rx_reg,
                      partner_an_reg};

  assign vcfg_value = {cfg_reg[`REG_DATA_W-1:`VCFG_SM_RESET_BIT+1],
                       sm_active,
                       cfg_reg[`VCFG_SM_RESET_BIT-1:0]};

  // Read data is registered; other addresses read as zero
  always @*
  begin
    rdata_next = rdata_reg;
    if (reg_rd_i)
    begin
      if (sel_exp)
      begin
        rdata_next = exp_value;
      end
      else if (sel_vcfg)
      begin
        rdata_next = vcfg_value;
      end
      else
      begin
        rdata_next = {`REG_DATA_W{1'b0}};
      end
    end
  end

  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rdata_reg  <= {`REG_DATA_W{1'b0}};
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= reg_rd_i;
    end
  end

  assign reg_rdata_o  = rdata_reg;
  assign reg_rvalid_o = rvalid_reg;

  // Alignment bypass takes the whole symbol path with it; built from the next
  // state so the flopped outputs change on the same edge as the register
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      byp_coding_reg <= 1'b0;
      byp_scr_reg    <= 1'b0;
      sm_rst_reg     <= 1'b0;
    end
    else
    begin
      byp_coding_reg <= cfg_next[`VCFG_BYP_CODING_BIT] | cfg_next[`VCFG_BYP_ALIGN_BIT];
      byp_scr_reg    <= cfg_next[`VCFG_BYP_SCR_BIT] | cfg_next[`VCFG_BYP_ALIGN_BIT];
      sm_rst_reg     <= (sm_cnt_next != {`SM_CNT_W{1'b0}});
    end
  end

  assign bypass_block_coding_o     = byp_coding_reg;
  assign bypass_scrambling_o       = byp_scr_reg;
  assign bypass_symbol_alignment_o = cfg_reg[`VCFG_BYP_ALIGN_BIT];
  assign bypass_adaptation_ok_o    = cfg_reg[`VCFG_BYP_ADPOK_BIT];

  // Mode controls
  assign repeater_mode_o          = cfg_reg[`VCFG_REPEATER_BIT];
  assign tx100_mode_o             = cfg_reg[`VCFG_TX100_BIT];
  assign rmii_enable_o            = cfg_reg[`VCFG_RMII_BIT];
  assign auto_power_down_enable_o = cfg_reg[`VCFG_AUTO_PD_BIT];
  assign mgmt_preamble_suppress_o = cfg_reg[`VCFG_PREAMBLE_SUP_BIT];
  assign sleep_o                  = cfg_reg[`VCFG_SLEEP_BIT];
  assign remote_loopback_o        = cfg_reg[`VCFG_REMOTE_LOOP_BIT];
  assign state_machine_reset_o    = sm_rst_reg;

  // Link and LED outputs, registered to keep them glitch free
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      link_good_reg <= 1'b0;
      speed_led_reg <= 1'b0;
      fdx_led_reg   <= 1'b0;
    end
    else
    begin
      link_good_reg <= cfg_reg[`VCFG_FORCE_LINK_BIT] | line_link_100_i;
      speed_led_reg <= ~cfg_reg[`VCFG_SPEED_LED_DIS_BIT] & speed_100_i;
      if (cfg_reg[`VCFG_COL_LED_SEL_BIT])
      begin
        fdx_led_reg <= full_duplex_i | collision_i;
      end
      else
      begin
        fdx_led_reg <= full_duplex_i;
      end
    end
  end

  assign link_100_good_o = link_good_reg;
  assign speed_led_o     = speed_led_reg;
  assign fdx_col_led_o   = fdx_led_reg;

endmodule // phy_autoneg_vendor_regs

/* rtl/phy_cfg_consts.vh */
`ifndef PHY_CFG_CONSTS_VH
`define PHY_CFG_CONSTS_VH

// Management register addresses
`define ADDR_AUTONEG_EXPANSION  5'h06
`define ADDR_VENDOR_CONFIG      5'h10
`define REG_ADDR_W              5
`define REG_DATA_W              16

// Expansion register fields
`define EXP_PARTNER_AN_BIT      0
`define EXP_PAGE_RX_BIT         1
`define EXP_LOCAL_NP_BIT        2
`define EXP_PARTNER_NP_BIT      3
`define EXP_PDF_BIT             4
`define EXP_RESERVED_VALUE      11'h000

// Vendor configuration register fields
`define VCFG_REMOTE_LOOP_BIT    0
`define VCFG_SLEEP_BIT          1
`define VCFG_PREAMBLE_SUP_BIT   2
`define VCFG_SM_RESET_BIT       3
`define VCFG_AUTO_PD_BIT        4
`define VCFG_COL_LED_SEL_BIT    5
`define VCFG_SPEED_LED_DIS_BIT  6
`define VCFG_FORCE_LINK_BIT     7
`define VCFG_RMII_BIT           8
`define VCFG_RESERVED_BIT       9
`define VCFG_TX100_BIT          10
`define VCFG_REPEATER_BIT       11
`define VCFG_BYP_ADPOK_BIT      12
`define VCFG_BYP_ALIGN_BIT      13
`define VCFG_BYP_SCR_BIT        14
`define VCFG_BYP_CODING_BIT     15

// Reset image and the bits that a plain write may store
`define VCFG_RESET_VALUE        16'h1614
`define VCFG_RW_MASK            16'hFDF7
`define VCFG_RESERVED_VALUE     1'b1

// Timing
`define SM_RESET_CYCLES         16
`define SM_CNT_W                8
`define STRAP_LOAD_COUNT        2'h2
`define STRAP_DONE_COUNT        2'h3
`define SYNC_STAGES             2

`endif

/* rtl/pin_sync.v */
module pin_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clk_i,
  input  wire             rstn_i,
  // Pins and synchronised copy
  input  wire [WIDTH-1:0] pin_i,
  output wire [WIDTH-1:0] sync_o
);

  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second stage
  always @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1_reg <= pin_i;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_o = stage2_reg;

endmodule // pin_sync

/* testbench/mgmt_station.sv */
module mgmt_station (
  // Clock
  input  wire         clk_i,
  // Register port towards the device
  output logic [4:0]  reg_addr_o  = 5'h00,
  output logic        reg_wr_o    = 1'b0,
  output logic [15:0] reg_wdata_o = 16'h0000,
  output logic        reg_rd_o    = 1'b0,
  input  wire  [15:0] reg_rdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  // Data is inverted once taken, so a stale bus never looks valid
  task automatic wr(input [4:0] a, input [15:0] d);
    @(posedge clk_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;
  endtask
  // Expansion reads clear latched flags, so callers read it on purpose only
  task automatic rd(input [4:0] a, output [15:0] d);
    @(posedge clk_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_i);
    reg_rd_o   <= 1'b0;
    @(negedge clk_i);
    d = reg_rdata_i;
  endtask
endmodule // mgmt_station

/* testbench/phy_regs_props.sv */
module phy_regs_props #(
  parameter SM_RESET_CYCLES = 16
) (
  // Watched ports
  input wire        clk_i,
  input wire        rstn_i,
  input wire [4:0]  reg_addr_i,
  input wire        reg_wr_i,
  input wire [15:0] reg_wdata_i,
  input wire        reg_rd_i,
  input wire [15:0] reg_rdata_o,
  input wire        parallel_detect_fault_i,
  input wire        page_received_i,
  input wire        bypass_block_coding_o,
  input wire        bypass_scrambling_o,
  input wire        sleep_o,
  input wire        state_machine_reset_o,
  input wire        link_100_good_o,
  input wire        speed_led_o
);
  timeunit 1ns;
  timeprecision 1ns;
  wire       rd_exp  = reg_rd_i && reg_addr_i == 5'h06;
  wire       wr_cfg  = reg_wr_i && reg_addr_i == 5'h10;
  wire       sm_trig = wr_cfg && (reg_wdata_i[3] || (sleep_o && !reg_wdata_i[1]));
  reg  [7:0] sm_cnt_reg;
  // Restart on each trigger, a retrigger legally stretches the pulse
  always @(posedge clk_i)
    if (!rstn_i || sm_trig)
      sm_cnt_reg <= 8'h00;
    else if (state_machine_reset_o)
      sm_cnt_reg <= sm_cnt_reg + 8'h01;
    else
      sm_cnt_reg <= 8'h00;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rstn_i);
  AST_EXP_RSV: assert property (rd_exp |=>
    {reg_rdata_o[15:5], reg_rdata_o[2]} == 12'h000) else $error("Expansion zero bits set");
  AST_PDF_SET: assert property (parallel_detect_fault_i ##1 !rd_exp ##1 rd_exp |=>
    reg_rdata_o[4]) else $error("Fault flag not latched");
  AST_PAGE_SET: assert property (page_received_i ##1 !rd_exp ##1 rd_exp |=>
    reg_rdata_o[1]) else $error("Page flag not latched");
  AST_PAGE_CLR: assert property (rd_exp && !page_received_i ##1 !page_received_i
    ##1 rd_exp && !page_received_i |=> !reg_rdata_o[1]) else $error("Page flag not cleared");
  AST_SM_START: assert property (sm_trig |=> state_machine_reset_o)
    else $error("State reset pulse missing");
  AST_SM_LEN: assert property ($fell(state_machine_reset_o) |->
    sm_cnt_reg == SM_RESET_CYCLES) else $error("State reset pulse length wrong");
  AST_WAKE: assert property (wr_cfg && sleep_o && !reg_wdata_i[1] |=>
    state_machine_reset_o && !sleep_o) else $error("Wake did not reset state machines");
  AST_FORCE_LINK: assert property (wr_cfg && reg_wdata_i[7] |=> ##1 link_100_good_o)
    else $error("Forced link not reported");
  AST_SPEED_LED: assert property (wr_cfg && reg_wdata_i[6] |=> ##1 !speed_led_o)
    else $error("Speed LED not disabled");
  AST_CODING: assert property (wr_cfg |=>
    bypass_block_coding_o == ($past(reg_wdata_i[15]) | $past(reg_wdata_i[13])) &&
    bypass_scrambling_o == ($past(reg_wdata_i[14]) | $past(reg_wdata_i[13])))
    else $error("Bypass outputs do not follow write");
  cover property (sm_trig);
  cover property (page_received_i ##1 !rd_exp ##1 rd_exp);
  cover property (wr_cfg && sleep_o && !reg_wdata_i[1]);
endmodule // phy_regs_props

bind phy_autoneg_vendor_regs phy_regs_props #(.SM_RESET_CYCLES(SM_RESET_CYCLES)) u_props (
  .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .parallel_detect_fault_i(parallel_detect_fault_i), .page_received_i(page_received_i),
  .bypass_block_coding_o(bypass_block_coding_o), .bypass_scrambling_o(bypass_scrambling_o),
  .sleep_o(sleep_o), .state_machine_reset_o(state_machine_reset_o),
  .link_100_good_o(link_100_good_o), .speed_led_o(speed_led_o));

/* testbench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam SMC = 4;
  logic        clk_i  = 1'b0;
  logic        rstn_i = 1'b0;
  logic        parallel_detect_fault = 1'b0, page = 1'b0, pnp = 1'b0, pan = 1'b0;
  logic        spd = 1'b0, fdx = 1'b0, col = 1'b0, lnk = 1'b0;
  logic        rep_strap = 1'b1, rmii_strap = 1'b0;
  wire  [4:0]  addr;
  wire         wr, rd, rv;
  wire  [15:0] wd, rdat;
  wire  [14:0] o;
  logic [15:0] v, n;
  logic [15:0] tw [3] = '{16'h8000, 16'h4000, 16'h2000};
  logic [2:0]  te [3] = '{3'b100, 3'b010, 3'b111};
  int          failures = 0, check_count = 0;

  mgmt_station u_sme (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wd),
    .reg_rd_o(rd), .reg_rdata_i(rdat));
  phy_autoneg_vendor_regs #(.SM_RESET_CYCLES(SMC)) u_dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wd),
    .reg_rd_i(rd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .parallel_detect_fault_i(parallel_detect_fault), .page_received_i(page), .partner_next_page_i(pnp),
    .partner_autoneg_i(pan), .repeater_strap_i(rep_strap), .rmii_strap_i(rmii_strap),
    .line_link_100_i(lnk), .speed_100_i(spd), .full_duplex_i(fdx), .collision_i(col),
    .bypass_block_coding_o(o[14]), .bypass_scrambling_o(o[13]),
    .bypass_symbol_alignment_o(o[12]), .bypass_adaptation_ok_o(o[11]),
    .repeater_mode_o(o[10]), .tx100_mode_o(o[9]), .rmii_enable_o(o[8]),
    .auto_power_down_enable_o(o[7]), .mgmt_preamble_suppress_o(o[6]), .sleep_o(o[5]),
    .remote_loopback_o(o[4]), .state_machine_reset_o(o[3]), .link_100_good_o(o[2]),
    .speed_led_o(o[1]), .fdx_col_led_o(o[0]));

  initial
  begin
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input [15:0] got, input [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input [4:0] a, input [15:0] e);
    u_sme.rd(a, v);
    chk(v, e);
    chk({15'h0000, rv}, 16'h0001);
  endtask
  task automatic w(input [4:0] a, input [15:0] d);
    u_sme.wr(a, d);
    @(negedge clk_i);
  endtask

  task automatic t_reset;
    rc(5'h10, 16'h1E14);
    rc(5'h06, 16'h0000);
    rc(5'h01, 16'h0000);
    chk({1'b0, o}, 16'h0EC0);
  endtask
  task automatic t_exp;
    w(5'h06, 16'hFFFF);
    rc(5'h06, 16'h0000);
    @(posedge clk_i);
    {pan, pnp, parallel_detect_fault, page} <= 4'hF;
    @(posedge clk_i);
    {parallel_detect_fault, page} <= 2'h0;
    rc(5'h06, 16'h001B);
    rc(5'h06, 16'h0009);
    @(posedge clk_i);
    {pan, pnp} <= 2'h0;
    rc(5'h06, 16'h0000);
  endtask
  task automatic t_cfg;
    w(5'h10, 16'hFFF5);
    rc(5'h10, 16'hFFF5);
    chk({1'b0, o} & 16'h7FF0, 16'h7FD0);
    w(5'h10, 16'h0000);
    rc(5'h10, 16'h0200);
    chk({1'b0, o} & 16'h7FF0, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      w(5'h10, tw[i]);
      chk({13'h0000, o[14:12]}, {13'h0000, te[i]});
    end
  endtask
  task automatic t_led;
    @(posedge clk_i);
    {spd, col} <= 2'h3;
    w(5'h10, 16'h0000);
    @(negedge clk_i);
    chk({13'h0000, o[2:0]}, 16'h0002);
    w(5'h10, 16'h00A0);
    @(negedge clk_i);
    chk({13'h0000, o[2:0]}, 16'h0007);
    w(5'h10, 16'h0040);
    @(negedge clk_i);
    chk({13'h0000, o[2:0]}, 16'h0000);
  endtask
  task automatic t_sm;
    w(5'h10, 16'h0008);
    n = 16'h0000;
    while (o[3] === 1'b1 && n < 16'h0040)
    begin
      n++;
      @(negedge clk_i);
    end
    chk(n, 16'(SMC));
    rc(5'h10, 16'h0200);
    w(5'h10, 16'h0002);
    chk({15'h0000, o[5]}, 16'h0001);
    w(5'h10, 16'h0011);
    chk({13'h0000, o[5:3]}, 16'h0003);
    repeat (SMC) @(posedge clk_i);
    rc(5'h10, 16'h0211);
  endtask
  // Second reset with the straps swapped: both strap bits must follow the pins
  task automatic t_strap;
    @(posedge clk_i);
    {rep_strap, rmii_strap} <= 2'h1;
    rstn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rc(5'h10, 16'h1714);
    chk({1'b0, o} & 16'h0500, 16'h0100);
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Tests need under a hundred cycles, so twenty thousand means a hang
  initial
  begin
    #400000;
    failures++;
    stop_test;
  end

  initial
  begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_reset;
    t_exp;
    t_cfg;
    t_led;
    t_sm;
    t_strap;
    stop_test;
  end
endmodule // tb_top
